// File: design/wake_seq.sv
// startup wake sequencer: shutdown to normal mode with progress flags
module wake_seq #(
    parameter int unsigned CYC_PER_MS = wake_seq_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // wake pins
    input  wire logic       THERM_TWO_IN,
    input  wire logic       LOAD_SENSE_IN,
    // measurement ready from the converter side
    input  wire logic       SWITCH_OK,
    // register port
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // outputs
    output logic            AUX_REG_ON,
    output logic            SWITCH_EN,
    output logic            NORMAL_MODE,
    output logic            ALARM_OUT,
    output logic            ALARM_OE,
    output logic            IRQ
);
    typedef enum logic [5:0] {
        S_SHUT = 6'h01,
        S_INIT = 6'h02,
        S_CONV = 6'h04,
        S_SCAN = 6'h08,
        S_WAIT = 6'h10,
        S_NORM = 6'h20
    } state_e;

    localparam int unsigned NF = wake_seq_pkg::NFLG;

    state_e                          state_q;
    logic [wake_seq_pkg::MS_W-1:0]   ms_q;
    logic [wake_seq_pkg::MS_W-1:0]   eval_q;
    logic                            tick;
    logic                            wake;
    logic                            fast;
    logic [7:0]                      cfg_q;
    logic [7:0]                      map_q;
    logic [NF-1:0]                   flag_q;
    logic [NF-1:0]                   sts_q;
    logic [NF-1:0]                   ien_q;
    logic [NF-1:0]                   ev;
    logic [wake_seq_pkg::MS_W-1:0]   t_done;
    logic [wake_seq_pkg::MS_W-1:0]   t_full;
    logic [wake_seq_pkg::MS_W-1:0]   t_sw;

    initial begin
        if (CYC_PER_MS < 2) $error("wake_seq needs at least two cycles per ms");
    end

    assign wake   = (state_q == S_SHUT) && (!THERM_TWO_IN || LOAD_SENSE_IN);
    assign fast   = cfg_q[wake_seq_pkg::CFG_FAST];
    // stage times picked by the fast conversion setting
    assign t_done = fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_DONE_FAST_MS)
                         : wake_seq_pkg::MS_W'(wake_seq_pkg::T_DONE_SLOW_MS);
    assign t_full = fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_FULL_FAST_MS)
                         : wake_seq_pkg::MS_W'(wake_seq_pkg::T_FULL_SLOW_MS);
    assign t_sw   = fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_SW_FAST_MS)
                         : wake_seq_pkg::MS_W'(wake_seq_pkg::T_SW_SLOW_MS);

    ms_tick #(.CYCLES(CYC_PER_MS)) u_tick (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .clr     (wake),
        .tick    (tick)
    );

    // elapsed ms since wake, zero at the wake instant
    always_ff @(posedge CLK) begin
        if (SYS_RST || wake) begin
            ms_q <= '0;
        end else if (tick && state_q != S_NORM && state_q != S_SHUT) begin
            ms_q <= ms_q + 1'b1;
        end
    end

    // stage machine
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= S_SHUT;
        end else begin
            case (state_q)
                S_SHUT: begin
                    if (wake) state_q <= S_INIT;
                end
                S_INIT: begin
                    if (ms_q == wake_seq_pkg::MS_W'(wake_seq_pkg::T_INIT_MS)) state_q <= S_CONV;
                end
                S_CONV: begin
                    if (ms_q == t_done) state_q <= S_SCAN;
                end
                S_SCAN: begin
                    if (ms_q == t_full) state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (ms_q == t_sw) state_q <= S_NORM;
                end
                S_NORM: begin
                    state_q <= S_NORM;
                end
                default: begin
                    state_q <= S_SHUT;
                end
            endcase
        end
    end

    // hardware flag events, one cycle each
    always_comb begin
        ev = '0;
        ev[wake_seq_pkg::FLG_INIT] = (state_q == S_INIT)
                                     && ms_q == wake_seq_pkg::MS_W'(wake_seq_pkg::T_INIT_MS);
        ev[wake_seq_pkg::FLG_DONE] = (state_q == S_CONV) && ms_q == t_done;
        ev[wake_seq_pkg::FLG_SCAN] = (state_q == S_CONV) && ms_q == t_done;
        ev[wake_seq_pkg::FLG_FULL] = (state_q == S_SCAN) && ms_q == t_full;
        ev[wake_seq_pkg::FLG_SW]   = (state_q == S_WAIT) && ms_q == t_sw
                                     && cfg_q[wake_seq_pkg::CFG_AUTO_SW];
    end

    // progress flags stay set until SYS_RST
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_q | ev;
        end
    end

    // sticky status; a set in the same cycle beats a clear
    generate
        for (genvar i = 0; i < NF; i++) begin : g_sts
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    sts_q[i] <= 1'b0;
                end else if (ev[i]) begin
                    sts_q[i] <= 1'b1;
                end else if (WR && ADDR == wake_seq_pkg::A_CLEAR && WDATA[i]) begin
                    sts_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // software registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q <= wake_seq_pkg::RST_CONFIG;
            map_q <= wake_seq_pkg::RST_ALARM_MAP;
            ien_q <= wake_seq_pkg::RST_IRQ_EN[NF-1:0];
        end else if (WR) begin
            case (ADDR)
                wake_seq_pkg::A_CONFIG:    cfg_q <= WDATA;
                wake_seq_pkg::A_ALARM_MAP: map_q <= WDATA;
                wake_seq_pkg::A_IRQ_EN:    ien_q <= WDATA[NF-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                wake_seq_pkg::A_STATUS:    RDATA <= {3'h0, sts_q};
                wake_seq_pkg::A_IRQ_EN:    RDATA <= {3'h0, ien_q};
                wake_seq_pkg::A_ALARM_MAP: RDATA <= map_q;
                wake_seq_pkg::A_CONFIG:    RDATA <= cfg_q;
                wake_seq_pkg::A_STATE:     RDATA <= {2'h0, state_q};
                default:                   RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // regulator: fixed 20 ms whatever the conversion speed
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            AUX_REG_ON <= 1'b0;
        end else if (state_q != S_SHUT && cfg_q[wake_seq_pkg::CFG_AUTO_REG]
                     && ms_q >= wake_seq_pkg::MS_W'(wake_seq_pkg::T_REG_MS)) begin
            AUX_REG_ON <= 1'b1;
        end
    end

    // periodic evaluation in normal mode; data ready earlier waits for the slot
    always_ff @(posedge CLK) begin
        if (SYS_RST || state_q != S_NORM) begin
            eval_q <= '0;
        end else if (tick) begin
            eval_q <= (eval_q == wake_seq_pkg::MS_W'(wake_seq_pkg::T_EVAL_MS - 1))
                      ? '0 : eval_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || !cfg_q[wake_seq_pkg::CFG_AUTO_SW]) begin
            SWITCH_EN <= 1'b0;
        end else if (ev[wake_seq_pkg::FLG_SW]) begin
            SWITCH_EN <= 1'b1;
        end else if (state_q == S_NORM && tick
                     && eval_q == wake_seq_pkg::MS_W'(wake_seq_pkg::T_EVAL_MS - 1)) begin
            SWITCH_EN <= SWITCH_OK;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            NORMAL_MODE <= 1'b0;
            ALARM_OUT   <= 1'b0;
            ALARM_OE    <= 1'b0;
            IRQ         <= 1'b0;
        end else begin
            NORMAL_MODE <= (state_q == S_NORM);
            ALARM_OUT   <= 1'b0;
            ALARM_OE    <= |(flag_q & map_q[NF-1:0]);
            IRQ         <= |(sts_q & ien_q);
        end
    end

    // checks
    sequence flag_rise_s(logic f);
        $rose(f) ##1 f;
    endsequence
    // a stage hands over to the next on a single edge
    sequence stage_step_s(state_e from_s, state_e to_s);
        state_q == from_s ##1 state_q == to_s;
    endsequence

    // progress flags at their times after wake
    init_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(flag_q[wake_seq_pkg::FLG_INIT])
        |-> $past(ms_q) == wake_seq_pkg::MS_W'(wake_seq_pkg::T_INIT_MS))
        else $error("init flag at wrong time");
    done_scan_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(flag_q[wake_seq_pkg::FLG_DONE]) == $rose(flag_q[wake_seq_pkg::FLG_SCAN]))
        else $error("done and scan flags disagree");
    done_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(flag_q[wake_seq_pkg::FLG_DONE])
        |-> $past(ms_q) == (fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_DONE_FAST_MS)
                                 : wake_seq_pkg::MS_W'(wake_seq_pkg::T_DONE_SLOW_MS)))
        else $error("done flag at wrong time");
    full_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(flag_q[wake_seq_pkg::FLG_FULL])
        |-> $past(ms_q) == (fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_FULL_FAST_MS)
                                 : wake_seq_pkg::MS_W'(wake_seq_pkg::T_FULL_SLOW_MS)))
        else $error("full scan flag at wrong time");

    // switch and regulator outputs
    sw_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(flag_q[wake_seq_pkg::FLG_SW])
        |-> $rose(SWITCH_EN)
            && $past(ms_q) == (fast ? wake_seq_pkg::MS_W'(wake_seq_pkg::T_SW_FAST_MS)
                                    : wake_seq_pkg::MS_W'(wake_seq_pkg::T_SW_SLOW_MS)))
        else $error("switch enable at wrong time");
    sw_auto_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !cfg_q[wake_seq_pkg::CFG_AUTO_SW] |=> !SWITCH_EN)
        else $error("switch enabled without autonomous control");
    reg_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(AUX_REG_ON) |-> $past(ms_q) >= wake_seq_pkg::MS_W'(wake_seq_pkg::T_REG_MS))
        else $error("regulator on too early");
    reg_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        AUX_REG_ON |=> AUX_REG_ON)
        else $error("regulator dropped before reset");
    reg_auto_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !cfg_q[wake_seq_pkg::CFG_AUTO_REG] && !AUX_REG_ON |=> !AUX_REG_ON)
        else $error("regulator on without auto option");

    // wake and stage order
    wake_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wake |=> ms_q == '0 && state_q == S_INIT)
        else $error("wake did not restart timing");
    wake_refused_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q != S_SHUT |=> state_q != S_SHUT)
        else $error("sequence fell back to shutdown");
    norm_order_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        flag_rise_s(NORMAL_MODE) |-> flag_q[wake_seq_pkg::FLG_FULL])
        else $error("normal mode before stages");
    // one-hot codes make each legal step a shift by one place
    stage_order_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $changed(state_q) |-> 6'(state_q) == 6'($past(state_q)) << 1)
        else $error("stage skipped or reversed");
    init_exit_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ev[wake_seq_pkg::FLG_INIT] |-> stage_step_s(S_INIT, S_CONV))
        else $error("init stage did not hand over");
    scan_exit_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ev[wake_seq_pkg::FLG_FULL] |-> stage_step_s(S_SCAN, S_WAIT))
        else $error("scan stage did not hand over");

    // elapsed time and the 250 ms slot
    // a jump here would let a stage target slip past and hang the walk
    ms_step_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $changed(ms_q) && !$past(wake) |-> ms_q == $past(ms_q) + 1'b1)
        else $error("elapsed time jumped");
    ms_freeze_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q == S_NORM |=> $stable(ms_q))
        else $error("elapsed time moved in normal mode");
    // turning the option off drops the switches at once, outside any slot
    sw_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_q == S_NORM && $changed(SWITCH_EN) && $past(state_q) == S_NORM
         && $past(cfg_q[wake_seq_pkg::CFG_AUTO_SW]))
        |-> $past(eval_q) == wake_seq_pkg::MS_W'(wake_seq_pkg::T_EVAL_MS - 1))
        else $error("switch decision off its slot");
    eval_range_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        eval_q < wake_seq_pkg::MS_W'(wake_seq_pkg::T_EVAL_MS))
        else $error("evaluation slot counter overran");

    // pin, status and register port
    // pin only ever pulls low; release is left to the pull-up
    alarm_oe_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 ALARM_OE == |($past(flag_q) & $past(map_q[NF-1:0])) && !ALARM_OUT)
        else $error("alarm pin mismatch");
    sts_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ev != '0 |=> (sts_q & $past(ev)) == $past(ev))
        else $error("status event lost to a clear");
    irq_level_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 IRQ == |($past(sts_q) & $past(ien_q)))
        else $error("interrupt level mismatch");
    // read data must not linger for a master that samples late
    rdata_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !RD |=> RDATA == 8'h00)
        else $error("read data outside its cycle");
endmodule

// File: design/wake_seq_pkg.sv
// shared constants for the startup wake sequencer
package wake_seq_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned MS_PER_SEC      = 1000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_SEC;
    // stage times in ms after the wake event, the normal-mode evaluation period and the ms counter width
    localparam int unsigned T_REG_MS        = 20;
    localparam int unsigned T_INIT_MS       = 23;
    localparam int unsigned T_DONE_SLOW_MS  = 88;
    localparam int unsigned T_DONE_FAST_MS  = 58;
    localparam int unsigned T_FULL_SLOW_MS  = 221;
    localparam int unsigned T_FULL_FAST_MS  = 129;
    localparam int unsigned T_SW_SLOW_MS    = 282;
    localparam int unsigned T_SW_FAST_MS    = 284;
    localparam int unsigned T_EVAL_MS       = 250;
    localparam int unsigned MS_W            = 10;
    // flag bit positions (status, enable, clear, alarm map)
    localparam int unsigned FLG_INIT        = 0;
    localparam int unsigned FLG_DONE        = 1;
    localparam int unsigned FLG_SCAN        = 2;
    localparam int unsigned FLG_FULL        = 3;
    localparam int unsigned FLG_SW          = 4;
    localparam int unsigned NFLG            = 5;
    // register offsets
    localparam logic [3:0] A_STATUS         = 4'h0;
    localparam logic [3:0] A_CLEAR          = 4'h1;
    localparam logic [3:0] A_IRQ_EN         = 4'h2;
    localparam logic [3:0] A_ALARM_MAP      = 4'h3;
    localparam logic [3:0] A_CONFIG         = 4'h4;
    localparam logic [3:0] A_STATE          = 4'h5;
    localparam logic [7:0] RST_ALARM_MAP    = 8'h00;
    localparam logic [7:0] RST_CONFIG       = 8'h00;
    localparam logic [7:0] RST_IRQ_EN       = 8'h00;
    // config bits
    localparam int unsigned CFG_FAST        = 0;
    localparam int unsigned CFG_AUTO_SW     = 1;
    localparam int unsigned CFG_AUTO_REG    = 2;
endpackage

// File: design/ms_tick.sv
// millisecond enable divider
module ms_tick #(
    parameter int unsigned CYCLES = 100_000
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic SYS_RST,
    // restart and tick
    input  wire logic clr,
    output logic      tick
);
    localparam int unsigned W = $clog2(CYCLES);
    logic [W-1:0] cnt_q;

    initial begin
        if (CYCLES < 2) $error("ms_tick needs at least two cycles");
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || clr) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == W'(CYCLES - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// File: verification/host_alarm_watch.sv
// host side of the alarm pin: pulled-up line as the host processor sees it
module host_alarm_watch (
    // device pin drive
    input  wire logic alarm_out,
    input  wire logic alarm_oe,
    // resolved line, low means alarm
    output logic      alarm_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin floats up to the pull-up, never keeps the last driven level
    assign alarm_line = alarm_oe ? alarm_out : 1'b1;
endmodule

// File: verification/test_wake_seq.sv
// self-checking bench for the startup wake sequencer
module test_wake_seq;
    timeunit 1ns;
    timeprecision 1ps;
    // short ms so a full sequence stays a few thousand cycles
    localparam int C     = 10;
    localparam int O_AUX = 0;
    localparam int O_PIN = 1;
    localparam int O_SW  = 2;
    localparam int O_IRQ = 4;
    logic       CLK, SYS_RST, THERM_TWO_IN, LOAD_SENSE_IN, SWITCH_OK, WR, RD;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA;
    logic       AUX_REG_ON, SWITCH_EN, NORMAL_MODE, ALARM_OUT, ALARM_OE, IRQ, alarm_line;
    logic [4:0] obs;
    int         n_errors = 0;
    int         checks = 0;
    int         cyc = 0;
    int         t0 = 0;

    assign obs = {IRQ, NORMAL_MODE, SWITCH_EN, ~alarm_line, AUX_REG_ON};

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;

    wake_seq #(.CYC_PER_MS(C)) i_dut (
        .CLK(CLK), .SYS_RST(SYS_RST), .THERM_TWO_IN(THERM_TWO_IN), .LOAD_SENSE_IN(LOAD_SENSE_IN),
        .SWITCH_OK(SWITCH_OK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .AUX_REG_ON(AUX_REG_ON), .SWITCH_EN(SWITCH_EN), .NORMAL_MODE(NORMAL_MODE),
        .ALARM_OUT(ALARM_OUT), .ALARM_OE(ALARM_OE), .IRQ(IRQ));
    host_alarm_watch i_host (.alarm_out(ALARM_OUT), .alarm_oe(ALARM_OE), .alarm_line(alarm_line));

    task automatic summarize;
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge CLK);
        #1;
    endtask
    // wake pulse; t0 is the edge that takes it
    task automatic wake(input bit use_load);
        @(posedge CLK);
        if (use_load) LOAD_SENSE_IN <= 1'b1;
        else THERM_TWO_IN <= 1'b0;
        @(posedge CLK);
        t0 = cyc;
        LOAD_SENSE_IN <= 1'b0;
        THERM_TWO_IN  <= 1'b1;
    endtask
    task automatic wait_ms(input int ms);
        int i;
        for (i = 0; i < 8000 && cyc - t0 < ms * C; i++) @(posedge CLK);
        #1;
        if (i == 8000) begin
            n_errors++;
            $display("[FAIL] %0t ns: wait for %0d ms timed out", $time, ms);
            summarize();
        end
    endtask
    // window is tight enough that one ms off is caught
    task automatic wait_obs(input int idx, input int ms);
        int i;
        for (i = 0; i < 6000 && obs[idx] !== 1'b1; i++) @(posedge CLK);
        checks++;
        if (i == 6000 || cyc - t0 < ms * C - 2 || cyc - t0 > ms * C + 8) begin
            n_errors++;
            $display("[FAIL] %0t ns: output %0d rose after %0d cycles", $time, idx, cyc - t0);
            if (i == 6000) summarize();
        end
    endtask

    initial begin
        SYS_RST       = 1'b1;
        THERM_TWO_IN  = 1'b1;
        LOAD_SENSE_IN = 1'b0;
        SWITCH_OK     = 1'b0;
        ADDR          = 4'h0;
        WDATA         = 8'h00;
        WR            = 1'b0;
        RD            = 1'b0;
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        settle();
        chk({AUX_REG_ON, SWITCH_EN, NORMAL_MODE, ALARM_OE, IRQ}, 0);
        chk(alarm_line, 1'b1);
        wr(4'hF, 8'hFF);
        rd_chk(wake_seq_pkg::A_CONFIG, wake_seq_pkg::RST_CONFIG);
        rd_chk(wake_seq_pkg::A_ALARM_MAP, wake_seq_pkg::RST_ALARM_MAP);
        rd_chk(wake_seq_pkg::A_IRQ_EN, wake_seq_pkg::RST_IRQ_EN);
        rd_chk(wake_seq_pkg::A_STATUS, 8'h00);
        rd_chk(wake_seq_pkg::A_STATE, 8'h01);
        rd_chk(4'hF, 8'h00);
        // slow conversion, auto switch and auto regulator
        wr(wake_seq_pkg::A_CONFIG, 8'h06);
        wr(wake_seq_pkg::A_ALARM_MAP, 8'h01);
        wr(wake_seq_pkg::A_IRQ_EN, 8'h02);
        @(posedge CLK);
        SWITCH_OK <= 1'b1;
        wake(1'b1);
        wait_obs(O_AUX, 20);
        wait_obs(O_PIN, 23);
        wait_obs(O_IRQ, 88);
        rd_chk(wake_seq_pkg::A_STATUS, 8'h07);
        wr(wake_seq_pkg::A_ALARM_MAP, 8'h08);
        settle();
        chk(alarm_line, 1'b1);
        wait_obs(O_PIN, 221);
        chk(NORMAL_MODE, 1'b0);
        wait_obs(O_SW, 282);
        wait_ms(290);
        chk(NORMAL_MODE, 1'b1);
        rd_chk(wake_seq_pkg::A_STATE, 8'h20);
        // measurement turns bad; switches must wait for the next slot
        @(posedge CLK);
        SWITCH_OK <= 1'b0;
        wait_ms(480);
        chk(SWITCH_EN, 1'b1);
        wait_ms(545);
        chk(SWITCH_EN, 1'b0);
        wr(wake_seq_pkg::A_IRQ_EN, 8'h00);
        settle();
        chk(IRQ, 1'b0);
        wr(wake_seq_pkg::A_IRQ_EN, 8'h02);
        settle();
        chk(IRQ, 1'b1);
        wr(wake_seq_pkg::A_CLEAR, 8'h02);
        settle();
        chk(IRQ, 1'b0);
        wr(wake_seq_pkg::A_STATUS, 8'hFF);
        rd_chk(wake_seq_pkg::A_STATUS, 8'h1D);
        wake(1'b0);
        rd_chk(wake_seq_pkg::A_STATE, 8'h20);
        // second run: fast conversion, regulator left to the host
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        wr(wake_seq_pkg::A_CONFIG, 8'h03);
        wr(wake_seq_pkg::A_ALARM_MAP, 8'h08);
        wr(wake_seq_pkg::A_IRQ_EN, 8'h02);
        @(posedge CLK);
        SWITCH_OK <= 1'b1;
        wake(1'b0);
        wait_obs(O_IRQ, 58);
        wait_obs(O_PIN, 129);
        wait_obs(O_SW, 284);
        chk(AUX_REG_ON, 1'b0);
        summarize();
    end
endmodule
